// ===== core/wsb_addr_ctr.sv
// one bank/column/row address counter of the sequencer
`timescale 1ns/100ps
`include "wsb_consts.svh"
module wsb_addr_ctr (
	input wire logic mclk,  // clock
	input wire logic reset, // asynchronous reset, active high
	wsb_ctr_if.ctr   c      // commands in, address out
);
	import wsb_pkg::*;

	logic [`WSB_ROW_W-1:0]  row_q, row_d;
	logic [`WSB_COL_W-1:0]  col_q, col_d;
	logic [`WSB_BANK_W-1:0] bank_q, bank_d;
	logic                   row_term;
	logic                   col_term;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		row_term = c.down ? (row_q == '0) : (row_q == `WSB_ROW_MAX);
		col_term = c.down ? (col_q == '0) : (col_q == `WSB_COL_MAX);
		row_d    = row_q;
		col_d    = col_q;
		bank_d   = bank_q;
		if (c.step_row) begin
			row_d = c.down ? row_q - 3'h1 : row_q + 3'h1;
		end
		// chained: column moves only on the row carry
		if (c.step_col && (!c.chain || row_term)) begin // RULE_09 RULE_11
			col_d = c.down ? col_q - 3'h1 : col_q + 3'h1;
		end
		if (c.step_bank) begin
			bank_d = bank_q + 1'h1;
		end
		if (c.clear) begin // RULE_10 RULE_11
			row_d  = '0;
			col_d  = '0;
			bank_d = '0;
		end else if (c.load) begin
			{bank_d, col_d, row_d} = c.load_val;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			row_q  <= '0;
			col_q  <= '0;
			bank_q <= '0;
		end else if (c.ce) begin
			row_q  <= row_d;
			col_q  <= col_d;
			bank_q <= bank_d;
		end
	end

	assign c.row  = row_q;
	assign c.col  = col_q;
	assign c.bank = bank_q;
	assign c.addr = {bank_q, col_q, row_q};
	assign c.nxt  = {bank_d, col_d, row_d};
	assign c.wrap = row_term & col_term;
endmodule : wsb_addr_ctr

// ===== core/wsb_consts.svh
// constants of the walking and surround self-test sequencer
`ifndef WSB_CONSTS_SVH
`define WSB_CONSTS_SVH

// memory geometry: bank, column and row segments
`define WSB_ROW_W      3
`define WSB_COL_W      3
`define WSB_BANK_W     1
`define WSB_ADDR_W     7
`define WSB_DATA_W     8
`define WSB_ROW_MAX    3'h7
`define WSB_COL_MAX    3'h7
`define WSB_BANK_MAX   1'h1

// data background and loop counter
`define WSB_DATA_BG    8'h00
`define WSB_LOOP_W     2
`define WSB_LOOP_END   2'h1
`define WSB_INNER_LAST 2'h3

// microprogram slots held by the sequencer
`define WSB_SLOT_COUNT 8
`define WSB_SLOT_MIN   3

`endif

// ===== core/wsb_ctr_if.sv
// command and address bundle between sequencer and one address counter
`timescale 1ns/100ps
`include "wsb_consts.svh"
interface wsb_ctr_if;
	logic                   ce;
	logic                   step_row;
	logic                   step_col;
	logic                   step_bank;
	logic                   down;
	logic                   chain;
	logic                   clear;
	logic                   load;
	logic [`WSB_ADDR_W-1:0] load_val;
	logic [`WSB_ADDR_W-1:0] nxt;
	logic [`WSB_ADDR_W-1:0] addr;
	logic [`WSB_ROW_W-1:0]  row;
	logic [`WSB_COL_W-1:0]  col;
	logic [`WSB_BANK_W-1:0] bank;
	logic                   wrap;

	modport ctrl (output ce, step_row, step_col, step_bank, down, chain,
		clear, load, load_val, input nxt, addr, row, col, bank, wrap);
	modport ctr (input ce, step_row, step_col, step_bank, down, chain,
		clear, load, load_val, output nxt, addr, row, col, bank, wrap);
endinterface : wsb_ctr_if

// ===== core/wsb_pkg.sv
// types of the walking and surround self-test sequencer
package wsb_pkg;
	typedef enum logic [3:0] {
		WSB_IDLE   = 4'h0,
		WSB_S0     = 4'h1,
		WSB_S1     = 4'h2,
		WSB_S2     = 4'h3,
		WSB_S3     = 4'h4,
		WSB_S4     = 4'h5,
		WSB_S5     = 4'h6,
		WSB_S6     = 4'h7,
		WSB_S7     = 4'h8,
		WSB_FINISH = 4'h9
	} wsb_slot_t;

	typedef enum logic {
		WSB_WALK = 1'h0,
		WSB_SURR = 1'h1
	} wsb_test_t;
endpackage : wsb_pkg

// ===== core/wsb_seq.sv
// walking-pattern and surround-disturb memory self-test sequencer
//
// How it works
// RULE_01 - walking test reruns background, home and bank phases with data inverted
// RULE_02 - write and expected data registers load all zeros before walking test
// RULE_03 - neighbour read sweeps secondary; expected inverted where addresses match
// RULE_04 - home restore is read-modify-write, advances primary, loops to home write
// RULE_05 - bank step copies primary into secondary, bumps bank, loops to background
// RULE_06 - walking test relies on primary/secondary address equality compare
// RULE_07 - memory port offers write, read and read-modify-write
// RULE_08 - microprogram offers at least three instruction slots
// RULE_09 - primary column counts only on row carry, at max up or min down
// RULE_10 - surround test starts primary bank, column and row at zero
// RULE_11 - surround secondary segments count independently from zero
// RULE_12 - surround write and expected data registers hold all zeros
// RULE_13 - loop counter end count is one, so each pair runs twice
// RULE_14 - first step writes true background min to max, row fastest
// RULE_15 - offset step decrements secondary row and column by one
// RULE_16 - base pass writes inverse at secondary, then column plus one
// RULE_17 - read true at primary, bump loop counter, loop to column write
// RULE_18 - base pass writes inverse at secondary, then row plus one
// RULE_19 - surround steps repeat with address, data, then both inverted
// RULE_20 - address-inverted repeats decrement secondary column and row
// RULE_21 - advance step bumps primary, copies to secondary, loops to offset
// RULE_22 - after all banks the surround program reruns with data inverted
// RULE_23 - flag read mismatches; signal done after the final step
`timescale 1ns/100ps
`include "wsb_consts.svh"
module wsb_seq (
	input  wire logic                   mclk,      // clock, 100 MHz
	input  wire logic                   reset,     // async reset, high
	input  wire logic                   ce,        // clock enable
	input  wire logic                   start,     // begin a test
	input  wsb_pkg::wsb_test_t          test_sel,  // walking or surround
	input  wire logic [`WSB_DATA_W-1:0] mem_rdata, // read data, 1 later
	output logic [`WSB_ADDR_W-1:0]      mem_addr,  // bank,column,row
	output logic [`WSB_DATA_W-1:0]      mem_wdata, // write data
	output logic                        mem_we,    // write strobe
	output logic                        mem_re,    // read strobe
	output logic                        busy,      // test running
	output logic                        done,      // test finished
	output logic                        fail       // mismatch seen
);
	import wsb_pkg::*;

	wsb_ctr_if a_c ();
	wsb_ctr_if b_c ();

	wsb_slot_t               state_q, state_d;
	wsb_test_t               test_q;
	logic [`WSB_DATA_W-1:0]  wreg_q;
	logic [`WSB_DATA_W-1:0]  ereg_q;
	logic [`WSB_LOOP_W-1:0]  loop_q;
	logic [`WSB_LOOP_W-1:0]  loop_end_q;
	logic [1:0]              inner_q;
	logic                    outer_q;
	logic [`WSB_DATA_W-1:0]  exp_q;
	logic [`WSB_DATA_W-1:0]  exp_pend_q;
	logic                    rd_pend_q;
	logic [`WSB_DATA_W-1:0]  bg;
	logic [`WSB_DATA_W-1:0]  ebg;
	logic [`WSB_DATA_W-1:0]  cmd_wdata;
	logic [`WSB_DATA_W-1:0]  cmd_exp;
	logic                    cmd_we;
	logic                    cmd_re;
	logic                    use_b;
	logic                    a_eq_b;
	logic                    walk;
	logic                    bank_step;
	logic                    loop_inc;
	logic                    loop_clr;
	logic                    inner_inc;
	logic                    inner_clr;
	logic                    outer_set;

	wsb_addr_ctr u_ctr_a (
		.mclk  (mclk),
		.reset (reset),
		.c     (a_c.ctr)
	);

	wsb_addr_ctr u_ctr_b (
		.mclk  (mclk),
		.reset (reset),
		.c     (b_c.ctr)
	);

	////////////////////////////////////////////////////////////////////////
	// microprogram decode
	assign walk   = (test_q == WSB_WALK);
	assign a_eq_b = (a_c.addr == b_c.addr); // RULE_06
	assign bg     = wreg_q ^ {`WSB_DATA_W{outer_q}}; // RULE_01 RULE_22
	assign ebg    = ereg_q ^ {`WSB_DATA_W{outer_q}};

	always_comb begin
		state_d       = state_q;
		a_c.ce        = ce;
		b_c.ce        = ce;
		a_c.step_row  = 1'h0;
		a_c.step_col  = 1'h0;
		a_c.step_bank = 1'h0;
		a_c.down      = 1'h0;
		a_c.chain     = 1'h1;
		a_c.clear     = 1'h0;
		a_c.load      = 1'h0;
		a_c.load_val  = '0;
		b_c.step_row  = 1'h0;
		b_c.step_col  = 1'h0;
		b_c.step_bank = 1'h0;
		b_c.down      = !walk && inner_q[0]; // RULE_20
		b_c.chain     = walk;
		b_c.clear     = 1'h0;
		b_c.load      = 1'h0;
		b_c.load_val  = a_c.nxt;
		cmd_we        = 1'h0;
		cmd_re        = 1'h0;
		use_b         = 1'h0;
		cmd_wdata     = bg;
		cmd_exp       = ebg;
		bank_step     = 1'h0;
		loop_inc      = 1'h0;
		loop_clr      = 1'h0;
		inner_inc     = 1'h0;
		inner_clr     = 1'h0;
		outer_set     = 1'h0;
		unique case (state_q)
			WSB_IDLE: begin
				if (start) begin
					a_c.clear = 1'h1; // RULE_10
					b_c.clear = 1'h1; // RULE_11
					state_d   = WSB_S0;
				end
			end
			WSB_S0: begin
				cmd_we       = 1'h1; // RULE_14
				a_c.step_row = 1'h1;
				a_c.step_col = 1'h1;
				if (a_c.wrap) begin
					state_d = WSB_S1;
				end
			end
			WSB_S1: begin
				if (walk) begin
					cmd_we    = 1'h1;
					cmd_wdata = ~bg;
				end else begin
					b_c.down     = 1'h1; // RULE_15
					b_c.step_row = 1'h1;
					b_c.step_col = 1'h1;
					loop_clr     = 1'h1;
					inner_clr    = 1'h1;
				end
				state_d = WSB_S2;
			end
			WSB_S2: begin
				use_b = 1'h1;
				if (walk) begin
					cmd_re       = 1'h1;
					cmd_exp      = ebg ^ {`WSB_DATA_W{a_eq_b}}; // RULE_03
					b_c.step_row = 1'h1;
					b_c.step_col = 1'h1;
					if (b_c.wrap) begin
						state_d = WSB_S3;
					end
				end else begin
					cmd_we       = 1'h1; // RULE_16 RULE_19
					cmd_wdata    = ~bg ^ {`WSB_DATA_W{inner_q[1]}};
					b_c.step_col = 1'h1;
					state_d      = WSB_S3;
				end
			end
			WSB_S3: begin
				cmd_re = 1'h1;
				if (walk) begin
					cmd_we       = 1'h1; // RULE_04 RULE_07
					cmd_exp      = ~ebg;
					a_c.step_row = 1'h1;
					a_c.step_col = 1'h1;
					state_d      = a_c.wrap ? WSB_S4 : WSB_S1;
				end else if (loop_q == loop_end_q) begin // RULE_17
					loop_clr = 1'h1;
					state_d  = WSB_S4;
				end else begin
					loop_inc = 1'h1;
					state_d  = WSB_S2;
				end
			end
			WSB_S4: begin
				if (walk) begin
					bank_step = 1'h1; // RULE_05
				end else begin
					cmd_we       = 1'h1; // RULE_18
					cmd_wdata    = ~bg ^ {`WSB_DATA_W{inner_q[1]}};
					use_b        = 1'h1;
					b_c.step_row = 1'h1;
					state_d      = WSB_S5;
				end
			end
			WSB_S5: begin
				cmd_re = 1'h1;
				// the row pair repeats on its own: with one shared counter,
				// going back to the column pair here would never end
				if (loop_q != loop_end_q) begin // RULE_17
					loop_inc = 1'h1;
					state_d  = WSB_S4;
				end else if (inner_q != `WSB_INNER_LAST) begin // RULE_19
					loop_clr  = 1'h1;
					inner_inc = 1'h1;
					state_d   = WSB_S2;
				end else begin
					loop_clr  = 1'h1;
					inner_clr = 1'h1;
					state_d   = WSB_S6;
				end
			end
			WSB_S6: begin
				a_c.step_row = 1'h1; // RULE_21
				a_c.step_col = 1'h1;
				b_c.load     = 1'h1;
				state_d      = a_c.wrap ? WSB_S7 : WSB_S1;
			end
			WSB_S7: begin
				bank_step = 1'h1;
			end
			WSB_FINISH: begin
				state_d = WSB_IDLE;
			end
			default: begin
				state_d = WSB_IDLE;
			end
		endcase
		// bank advance shared by both programs: copy the stepped primary
		if (bank_step) begin
			a_c.step_bank = 1'h1; // RULE_05
			b_c.load      = 1'h1;
			if (a_c.bank != `WSB_BANK_MAX) begin
				state_d = WSB_S0;
			end else if (!outer_q) begin
				outer_set = 1'h1; // RULE_01 RULE_22
				state_d   = WSB_S0;
			end else begin
				state_d = WSB_FINISH; // RULE_23
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sequencing state
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			state_q <= WSB_IDLE;
		end else if (ce) begin
			state_q <= state_d;
		end
	end

	// test registers loaded at start; the walking test and the surround
	// test share the same zero background
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			test_q     <= WSB_WALK;
			wreg_q     <= `WSB_DATA_BG;
			ereg_q     <= `WSB_DATA_BG;
			loop_end_q <= `WSB_LOOP_END;
		end else if (ce && state_q == WSB_IDLE && start) begin
			test_q     <= test_sel;
			wreg_q     <= `WSB_DATA_BG; // RULE_02 RULE_12
			ereg_q     <= `WSB_DATA_BG; // RULE_02 RULE_12
			loop_end_q <= `WSB_LOOP_END; // RULE_13
		end
	end

	// loop counter and the two repeat loops
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			loop_q  <= '0;
			inner_q <= '0;
			outer_q <= 1'h0;
		end else if (ce) begin
			if (state_q == WSB_IDLE) begin
				loop_q  <= '0;
				inner_q <= '0;
				outer_q <= 1'h0;
			end else begin
				if (loop_clr) begin
					loop_q <= '0;
				end else if (loop_inc) begin
					loop_q <= loop_q + 2'h1; // RULE_17
				end
				if (inner_clr) begin
					inner_q <= '0;
				end else if (inner_inc) begin
					inner_q <= inner_q + 2'h1; // RULE_19
				end
				if (outer_set) begin
					outer_q <= 1'h1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registered memory command; read data is compared one cycle later
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			mem_we    <= 1'h0;
			mem_re    <= 1'h0;
			mem_addr  <= '0;
			mem_wdata <= '0;
			exp_q     <= '0;
		end else if (ce) begin
			mem_we    <= cmd_we; // RULE_07
			mem_re    <= cmd_re;
			mem_addr  <= use_b ? b_c.addr : a_c.addr;
			mem_wdata <= cmd_wdata;
			exp_q     <= cmd_exp;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			rd_pend_q  <= 1'h0;
			exp_pend_q <= '0;
		end else if (ce) begin
			rd_pend_q  <= mem_re;
			exp_pend_q <= exp_q;
		end
	end

	// fail is sticky until the next start; start clears before any
	// compare of the new run can arrive, so no event is lost
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			fail <= 1'h0;
			done <= 1'h0;
			busy <= 1'h0;
		end else if (ce) begin
			if (rd_pend_q && mem_rdata != exp_pend_q) begin
				fail <= 1'h1; // RULE_23
			end else if (state_q == WSB_IDLE && start) begin
				fail <= 1'h0;
			end
			if (state_q == WSB_FINISH) begin
				done <= 1'h1; // RULE_23
				busy <= 1'h0;
			end else if (state_q == WSB_IDLE && start) begin
				done <= 1'h0;
				busy <= 1'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	sequence s_pair;
		(state_q == WSB_S2 && ce) ##1 (state_q == WSB_S3 && ce);
	endsequence

	a_bg_zero: assert property (@(posedge mclk) disable iff (reset) // RULE_02
		(state_q == WSB_S0 && !outer_q && ce) |=> mem_we && mem_wdata == '0)
		else $error("background write is not zero");

	a_loop_twice: assert property (@(posedge mclk) disable iff (reset) // RULE_17
		(s_pair ##0 test_q == WSB_SURR) |=>
		state_q == (($past(loop_q) == `WSB_LOOP_END) ? WSB_S4 : WSB_S2))
		else $error("loop counter pair count wrong");

	a_offset_step: assert property (@(posedge mclk) disable iff (reset) // RULE_15
		(state_q == WSB_S1 && test_q == WSB_SURR && ce) |=>
		b_c.row == $past(b_c.row) - 3'h1 && b_c.col == $past(b_c.col) - 3'h1)
		else $error("offset step did not decrement secondary");

	a_col_step: assert property (@(posedge mclk) disable iff (reset) // RULE_20
		(state_q == WSB_S2 && test_q == WSB_SURR && ce) |=>
		b_c.col == ($past(inner_q[0]) ? $past(b_c.col) - 3'h1
			: $past(b_c.col) + 3'h1))
		else $error("secondary column step direction wrong");

	a_row_carry: assert property (@(posedge mclk) disable iff (reset) // RULE_09
		(a_c.step_col && !a_c.clear && !a_c.load && ce) |=>
		(a_c.col != $past(a_c.col)) == ($past(a_c.row) == `WSB_ROW_MAX))
		else $error("primary column moved without row carry");

	a_inv_rerun: assert property (@(posedge mclk) disable iff (reset) // RULE_01
		(bank_step && a_c.bank == `WSB_BANK_MAX && !outer_q && ce) |=>
		(outer_q && state_q == WSB_S0) and (ce |=> mem_wdata == ~wreg_q))
		else $error("inverted rerun not started");

	a_away_inv: assert property (@(posedge mclk) disable iff (reset) // RULE_03
		(state_q == WSB_S2 && walk && ce) |=>
		mem_re && ((exp_q != ebg) == (mem_addr == a_c.addr)))
		else $error("neighbour read expect not inverted on match");

	a_finish_done: assert property (@(posedge mclk) disable iff (reset) // RULE_23
		(state_q == WSB_FINISH && ce) |=> done && !busy ##0 state_q == WSB_IDLE)
		else $error("completion not signalled");

	a_fail_flag: assert property (@(posedge mclk) disable iff (reset) // RULE_23
		(rd_pend_q && mem_rdata != exp_pend_q && ce) |=> fail)
		else $error("mismatch not flagged");

	a_loop_end: assert property (@(posedge mclk) disable iff (reset) // RULE_13
		busy |-> loop_end_q == `WSB_LOOP_END && `WSB_SLOT_COUNT >= `WSB_SLOT_MIN)
		else $error("loop end count or slot count wrong"); // RULE_08
endmodule : wsb_seq

// ===== dv/walking_surround_bist_sequencer_tb.sv
// self-checking bench of the walking and surround self-test sequencer
`timescale 1ns/100ps
`include "wsb_consts.svh"
module walking_surround_bist_sequencer_tb;
	import wsb_pkg::*;

	typedef struct {
		int         k;
		logic       we;
		logic       re;
		logic [6:0] addr;
		logic [7:0] wd;
	} wsb_row_t;

	logic       mclk;
	logic       reset;
	logic       ce;
	logic       start;
	wsb_test_t  test_sel;
	logic [7:0] mem_rdata;
	logic [6:0] mem_addr;
	logic [7:0] mem_wdata;
	logic       mem_we;
	logic       mem_re;
	logic       busy;
	logic       done;
	logic       fail;
	logic       corrupt;
	int         bad_count;
	int         checks;
	int         n_wr;
	int         n_rd;
	int         n_rmw;
	logic [7:0] last_wd;
	logic [6:0] stall_addr;
	logic       tr_we [0:79];
	logic       tr_re [0:79];
	logic [6:0] tr_addr [0:79];
	logic [7:0] tr_wd [0:79];

	// first steps of the surround test with an all-zero background
	wsb_row_t rows [16] = '{
		'{2, 1'b1, 1'b0, 7'h00, 8'h00}, '{3, 1'b1, 1'b0, 7'h01, 8'h00},
		'{10, 1'b1, 1'b0, 7'h08, 8'h00}, '{65, 1'b1, 1'b0, 7'h3f, 8'h00},
		'{66, 1'b0, 1'b0, 7'h00, 8'h00}, '{67, 1'b1, 1'b0, 7'h3f, 8'hff},
		'{68, 1'b0, 1'b1, 7'h00, 8'h00}, '{69, 1'b1, 1'b0, 7'h07, 8'hff},
		'{70, 1'b0, 1'b1, 7'h00, 8'h00}, '{71, 1'b1, 1'b0, 7'h0f, 8'hff},
		'{72, 1'b0, 1'b1, 7'h00, 8'h00}, '{73, 1'b1, 1'b0, 7'h08, 8'hff},
		'{74, 1'b0, 1'b1, 7'h00, 8'h00}, '{75, 1'b1, 1'b0, 7'h09, 8'hff},
		'{76, 1'b0, 1'b1, 7'h00, 8'h00}, '{77, 1'b1, 1'b0, 7'h01, 8'hff}};

	always #5 mclk = ~mclk;

	wsb_seq u_wsb_seq (
		.mclk      (mclk),
		.reset     (reset),
		.ce        (ce),
		.start     (start),
		.test_sel  (test_sel),
		.mem_rdata (mem_rdata),
		.mem_addr  (mem_addr),
		.mem_wdata (mem_wdata),
		.mem_we    (mem_we),
		.mem_re    (mem_re),
		.busy      (busy),
		.done      (done),
		.fail      (fail)
	);

	wsb_sram_model u_wsb_sram_model (
		.mclk    (mclk),
		.ce      (ce),
		.addr    (mem_addr),
		.wdata   (mem_wdata),
		.we      (mem_we),
		.re      (mem_re),
		.corrupt (corrupt),
		.rdata   (mem_rdata)
	);

	////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : print_verdict

	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// one whole test; ce drops for five cycles from stall_at, reads are
	// corrupted in [bad_lo,bad_hi), start stays high for hold cycles
	task automatic run_test(input wsb_test_t t, input int hold,
		input int stall_at, input int bad_lo, input int bad_hi);
		int k;
		k = 0;
		n_wr = 0;
		n_rd = 0;
		n_rmw = 0;
		start = 1'b1;
		test_sel = t;
		while (k < 2 || done !== 1'b1) begin
			@(negedge mclk);
			k++;
			if (k <= 79) begin
				tr_we[k] = mem_we;
				tr_re[k] = mem_re;
				tr_addr[k] = mem_addr;
				tr_wd[k] = mem_wdata;
			end
			if (k == 1) chk("busy", busy, 1);
			if (k == hold) start = 1'b0;
			if (k == stall_at) stall_addr = mem_addr;
			if (k == stall_at + 4) chk("stalled addr", mem_addr, stall_addr);
			if (bad_hi > 0 && k == bad_lo) chk("fail early", fail, 0);
			if (bad_hi > 0 && k == bad_hi + 10) chk("fail", fail, 1);
			ce = !(k >= stall_at && k < stall_at + 5);
			corrupt = (k >= bad_lo && k < bad_hi);
			if (ce && mem_we === 1'b1) begin
				n_wr++;
				last_wd = mem_wdata;
			end
			if (ce && mem_re === 1'b1) n_rd++;
			if (ce && mem_we === 1'b1 && mem_re === 1'b1) n_rmw++;
		end
		chk("busy at end", busy, 0);
	endtask : run_test

	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (60000) @(posedge mclk);
		bad_count++;
		print_verdict();
	end

	initial begin
		mclk = 1'b0;
		reset = 1'b1;
		ce = 1'b1;
		start = 1'b0;
		test_sel = WSB_WALK;
		corrupt = 1'b0;
		bad_count = 0;
		checks = 0;
		repeat (4) @(negedge mclk);
		chk("outputs in reset", {mem_we, mem_re, busy, done, fail, mem_addr}, 0);
		reset = 1'b0;

		// surround test, clean memory
		run_test(WSB_SURR, 1, -10, 0, 0);
		foreach (rows[i]) begin
			chk("mem_we", tr_we[rows[i].k], rows[i].we);
			chk("mem_re", tr_re[rows[i].k], rows[i].re);
			if (rows[i].we | rows[i].re) begin
				chk("mem_addr", tr_addr[rows[i].k], rows[i].addr);
			end
			if (rows[i].we) chk("mem_wdata", tr_wd[rows[i].k], rows[i].wd);
		end
		chk("surr writes", n_wr, 4352);
		chk("surr reads", n_rd, 4096);
		chk("surr last data", last_wd, 8'hff);
		chk("surr fail", fail, 0);
		chk("surr done", done, 1);

		// walking test back to back, with a clock-enable stall mid-run
		run_test(WSB_WALK, 1, 3000, 0, 0);
		chk("walk writes", n_wr, 768);
		chk("walk reads", n_rd, 16640);
		chk("walk rmw", n_rmw, 256);
		chk("walk last data", last_wd, 8'hff);
		chk("walk fail", fail, 0);
		chk("walk done", done, 1);

		// corrupted reads, start held high while busy must be ignored
		run_test(WSB_SURR, 100, -10, 60, 80);
		chk("held start writes", n_wr, 4352);
		chk("fail sticky", fail, 1);

		// restart clears fail, then a reset in mid-run
		start = 1'b1;
		test_sel = WSB_WALK;
		@(negedge mclk);
		start = 1'b0;
		@(negedge mclk);
		chk("fail cleared", fail, 0);
		chk("done cleared", done, 0);
		repeat (40) @(negedge mclk);
		reset = 1'b1;
		@(negedge mclk);
		chk("outputs after reset", {mem_we, mem_re, busy, done, fail, mem_addr}, 0);
		reset = 1'b0;
		@(negedge mclk);
		chk("idle after reset", busy, 0);
		print_verdict();
	end
endmodule : walking_surround_bist_sequencer_tb

// ===== dv/wsb_sram_model.sv
// behavioural synchronous memory standing behind the sequencer
`timescale 1ns/100ps
`include "wsb_consts.svh"
module wsb_sram_model (
	input  wire logic                   mclk,    // clock
	input  wire logic                   ce,      // clock enable, freezes all
	input  wire logic [`WSB_ADDR_W-1:0] addr,    // bank,column,row
	input  wire logic [`WSB_DATA_W-1:0] wdata,   // write data
	input  wire logic                   we,      // write strobe
	input  wire logic                   re,      // read strobe
	input  wire logic                   corrupt, // flip bit 0 of read data
	output logic      [`WSB_DATA_W-1:0] rdata    // read data, one later
);
	logic [`WSB_DATA_W-1:0] mem [0:(1<<`WSB_ADDR_W)-1];

	initial begin
		foreach (mem[i]) mem[i] = 8'ha5;
		rdata = 8'h5a;
	end

	////////////////////////////////////////////////////////////////////
	// read takes the old word, so we and re together act as read-modify-write
	// outside the valid cycle the data inverts, so stale data never matches
	always @(posedge mclk) begin
		if (ce) begin
			if (re) rdata <= mem[addr] ^ {7'h00, corrupt};
			else rdata <= ~rdata;
			if (we) mem[addr] <= wdata;
		end
	end
endmodule : wsb_sram_model
